// >>> rtl/bcb_regs.svh
`ifndef BCB_REGS_SVH
`define BCB_REGS_SVH

// ****************************************************************
// register map, byte offsets on the ahb-lite port
// ****************************************************************
`define BCB_ADDR_W     8
`define BCB_CTRL_OFF   8'h00
`define BCB_SET_BASE   8'h04
`define BCB_SET_LAST   8'h14
`define BCB_OCC_OFF    8'h18
`define BCB_CFGV_OFF   8'h1C
`define BCB_CFGM_OFF   8'h20

// ****************************************************************
// control fields and reset value
// ****************************************************************
`define BCB_CTRL_EN       0
`define BCB_CTRL_PROTO_LO 1
`define BCB_CTRL_PROTO_HI 2
`define BCB_CTRL_NSET_LO  4
`define BCB_CTRL_NSET_HI  5
`define BCB_CTRL_FLUSH    8
`define BCB_CTRL_RST      32'h0000_0001

// ****************************************************************
// channel setting fields, mask and reset value (default preset)
// ****************************************************************
`define BCB_SET_DEPTH_LO 0
`define BCB_SET_DEPTH_HI 4
`define BCB_SET_BYP      8
`define BCB_SET_PIPE     9
`define BCB_SET_KIND_LO  12
`define BCB_SET_KIND_HI  14
`define BCB_SET_MASK     32'h0000_731F
`define BCB_SET_RST      32'h0000_2000

// ****************************************************************
// preset depths, sizes and channel indices
// ****************************************************************
`define BCB_DEF_DEPTH  5'h02
`define BCB_ONE_DEPTH  5'h01
`define BCB_NONE_DEPTH 5'h00
`define BCB_MAX_DEPTH  5'h10
`define BCB_FIFO_DEPTH 16
`define BCB_DATA_W     32
`define BCB_NCH        5
`define BCB_CNT_W      5
`define BCB_CH_A       3'h0
`define BCB_CH_B       3'h1
`define BCB_CH_D       3'h3
`define BCB_AX_B       3'h2
`define BCB_AX_R       3'h4

`endif

// >>> rtl/bcb_pkg.sv
`include "bcb_regs.svh"

package bcb_pkg;
  // how a setting word is to be read
  typedef enum logic [2:0] {
    BCB_KIND_CUSTOM,
    BCB_KIND_INT,
    BCB_KIND_DEFAULT,
    BCB_KIND_NONE,
    BCB_KIND_BYPASS,
    BCB_KIND_PIPE
  } bcb_kind_t;
  // link protocol carried by the five lanes
  typedef enum logic [1:0] {
    BCB_TL_UL,
    BCB_TL_C,
    BCB_AXI,
    BCB_PROTO_RSV
  } bcb_proto_t;
  // number of settings supplied
  typedef enum logic [1:0] {
    BCB_NSET_ZERO,
    BCB_NSET_ONE,
    BCB_NSET_TWO,
    BCB_NSET_FIVE
  } bcb_nset_t;
  // read side of the register port
  typedef enum logic {
    BCB_AHB_IDLE,
    BCB_AHB_LOAD
  } bcb_ahb_st_t;
  // resolved queue shape of one channel
  typedef struct packed {
    logic [`BCB_CNT_W-1:0] depth;
    logic                  bypass;
    logic                  pipe;
  } bcb_cfg_t;
endpackage

// >>> rtl/bcb_fifo_if.sv
`timescale 1ns/10ps
`include "bcb_regs.svh"

// ****************************************************************
// link between the channel logic and its storage
// ****************************************************************
interface bcb_fifo_if #(
  parameter int WIDTH = `BCB_DATA_W
) ();
  logic                  clear;    // drop all entries
  logic                  wr_valid; // push request
  logic                  wr_ready; // room, or room made by a pop
  logic [WIDTH-1:0]      wr_data;  // pushed word
  logic                  rd_valid; // head present
  logic                  rd_ready; // pop request
  logic [WIDTH-1:0]      rd_data;  // registered head
  logic [`BCB_CNT_W-1:0] count;    // entries held

  modport store (
    input  clear, wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data, count
  );
  modport user (
    output clear, wr_valid, wr_data, rd_ready,
    input  wr_ready, rd_valid, rd_data, count
  );
endinterface

// >>> rtl/bcb_fifo.sv
`timescale 1ns/10ps
`include "bcb_regs.svh"

// ****************************************************************
// show-ahead fifo, head word held in a register
// ****************************************************************
// depth must be a power of two: pointers wrap by overflow
module bcb_fifo #(
  parameter int WIDTH = `BCB_DATA_W,
  parameter int DEPTH = `BCB_FIFO_DEPTH
) (
  // clock and reset
  input wire logic  hclk,
  input wire logic  hresetn,
  // storage side of the link
  bcb_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0]      mem [DEPTH]; // storage array
  logic [AW-1:0]         wr_ptr_reg;  // next free slot
  logic [AW-1:0]         rd_ptr_reg;  // head slot
  logic [AW-1:0]         rd_next;     // head slot after this cycle
  logic [`BCB_CNT_W-1:0] count_reg;   // entries held
  logic [WIDTH-1:0]      head_reg;    // registered head word
  logic                  push;
  logic                  pop;
  logic                  left_empty;  // nothing older left after pop

  // a pop frees the slot a push at full may take
  assign q.rd_valid = (count_reg != '0);
  assign pop        = q.rd_valid && q.rd_ready;
  assign q.wr_ready = (count_reg != `BCB_CNT_W'(DEPTH)) || pop;
  assign push       = q.wr_valid && q.wr_ready;
  assign rd_next    = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
  assign left_empty = pop ? (count_reg == `BCB_CNT_W'(1))
                          : (count_reg == '0);
  assign q.rd_data  = head_reg;
  assign q.count    = count_reg;

  // array write, no reset needed on data
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= q.wr_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (q.clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      end
      rd_ptr_reg <= rd_next;
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // head register: a new word lands here at once if nothing is older
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head_reg <= '0;
    end else if (push && left_empty) begin
      head_reg <= q.wr_data;
    end else begin
      head_reg <= mem[rd_next];
    end
  end
endmodule

// >>> rtl/bcb_bus_channel_buffer.sv
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "bcb_regs.svh"

// ****************************************************************
// bus channel buffer: one queue per decoupled channel of a link
// ****************************************************************
// How it works
// - one queue per channel, two or five
// - each queue holds exactly its depth
// - bypass lets a beat leave when entering
// - pipe ties input ready to output ready
// - plain integer: depth only, no options
// - four presets: default, none, bypass, pipelined
// - no settings: every channel uses default
// - one setting applies to all channels
// - two tilelink: first to a,c,e
// - five tilelink: a,b,c,d,e in order
// - two axi: first to aw,w,ar
// - axi one for all; five aw,w,b,ar,r
module bcb_bus_channel_buffer (
  // clock and reset
  input  wire logic                                  hclk,
  input  wire logic                                  hresetn,
  // ahb-lite register port
  input  wire logic                                  hsel,
  input  wire logic [31:0]                           haddr,
  input  wire logic [1:0]                            htrans,
  input  wire logic                                  hwrite,
  input  wire logic [2:0]                            hsize,
  input  wire logic [31:0]                           hwdata,
  input  wire logic                                  hready,
  output      logic                                  hreadyout,
  output      logic [31:0]                           hrdata,
  output      logic                                  hresp,
  // enqueue side of each channel
  input  wire logic [`BCB_NCH-1:0]                   src_valid,
  output      logic [`BCB_NCH-1:0]                   src_ready,
  input  wire logic [`BCB_NCH-1:0][`BCB_DATA_W-1:0]  src_data,
  // dequeue side of each channel
  output      logic [`BCB_NCH-1:0]                   dst_valid,
  input  wire logic [`BCB_NCH-1:0]                   dst_ready,
  output      logic [`BCB_NCH-1:0][`BCB_DATA_W-1:0]  dst_data
);
  import bcb_pkg::*;

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // turn one setting word into a queue shape
  function automatic bcb_cfg_t decode_setting(input logic [31:0] raw);
    bcb_cfg_t  c;
    bcb_kind_t k;
    c = '0;
    k = bcb_kind_t'(raw[`BCB_SET_KIND_HI:`BCB_SET_KIND_LO]);
    case (k)
      // plain integer: options forced off
      BCB_KIND_INT: begin
        c.depth = raw[`BCB_SET_DEPTH_HI:`BCB_SET_DEPTH_LO];
      end
      // the four presets
      BCB_KIND_DEFAULT: begin
        c.depth = `BCB_DEF_DEPTH;
      end
      BCB_KIND_NONE: begin
        c.depth = `BCB_NONE_DEPTH;
      end
      BCB_KIND_BYPASS: begin
        c.depth  = `BCB_ONE_DEPTH;
        c.bypass = 1'b1;
      end
      BCB_KIND_PIPE: begin
        c.depth = `BCB_ONE_DEPTH;
        c.pipe  = 1'b1;
      end
      // custom, and the two unused kind codes
      default: begin
        c.depth  = raw[`BCB_SET_DEPTH_HI:`BCB_SET_DEPTH_LO];
        c.bypass = raw[`BCB_SET_BYP];
        c.pipe   = raw[`BCB_SET_PIPE];
      end
    endcase
    // storage ends at sixteen words, larger asks are clipped
    if (c.depth > `BCB_MAX_DEPTH) begin
      c.depth = `BCB_MAX_DEPTH;
    end
    return c;
  endfunction

  // choose which setting word shapes a channel
  function automatic bcb_cfg_t resolve(
    input bcb_proto_t                        p,
    input bcb_nset_t                         n,
    input logic [2:0]                        ch,
    input logic [`BCB_NCH-1:0][31:0]         s
  );
    logic     back;
    bcb_cfg_t c;
    // lanes that flow from manager back to client
    if (p == BCB_AXI) begin
      back = (ch == `BCB_AX_B) || (ch == `BCB_AX_R);
    end else begin
      back = (ch == `BCB_CH_B) || (ch == `BCB_CH_D);
    end
    case (n)
      BCB_NSET_ZERO: c = decode_setting(`BCB_SET_RST);
      BCB_NSET_ONE:  c = decode_setting(s[0]);
      BCB_NSET_TWO:  c = decode_setting(back ? s[1] : s[0]);
      default:       c = decode_setting(s[ch]);
    endcase
    return c;
  endfunction

  // uncached tilelink only uses the a and d lanes
  function automatic logic chan_live(
    input bcb_proto_t p,
    input logic [2:0] ch
  );
    if (p == BCB_TL_UL) begin
      return (ch == `BCB_CH_A) || (ch == `BCB_CH_D);
    end
    return 1'b1;
  endfunction

  // address falls on one of the setting words
  function automatic logic is_set_addr(
    input logic [`BCB_ADDR_W-1:0] a
  );
    return (a >= `BCB_SET_BASE) && (a <= `BCB_SET_LAST) &&
           (a[1:0] == 2'h0);
  endfunction

  // setting word index from its address
  function automatic logic [2:0] set_index(
    input logic [`BCB_ADDR_W-1:0] a
  );
    logic [`BCB_ADDR_W-1:0] rel;
    rel = `BCB_ADDR_W'(a - `BCB_SET_BASE);
    return rel[4:2];
  endfunction

  // ****************************************************************
  // register state
  // ****************************************************************
  logic                              en_reg;      // channels enabled
  bcb_proto_t                        proto_reg;   // protocol on lanes
  bcb_nset_t                         nset_reg;    // settings supplied
  logic                              flush_reg;   // one-cycle flush
  logic [`BCB_NCH-1:0][31:0]         set_reg;     // setting words
  bcb_ahb_st_t                       ahb_st_reg;  // read wait state
  logic                              wr_pend_reg; // write data phase
  logic [`BCB_ADDR_W-1:0]            wr_addr_reg; // write address
  logic [`BCB_ADDR_W-1:0]            rd_addr_reg; // read address
  logic [31:0]                       hrdata_reg;  // read data
  logic                              take;        // address phase seen
  logic [31:0]                       rd_mux;      // read selection

  // per-channel views for the status words
  logic [`BCB_NCH*`BCB_CNT_W-1:0]    occ_flat;
  logic [`BCB_NCH*`BCB_CNT_W-1:0]    depth_flat;
  logic [`BCB_NCH-1:0]               byp_flat;
  logic [`BCB_NCH-1:0]               pipe_flat;
  logic [`BCB_NCH-1:0]               live_flat;

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************

  // transfer accepted on a nonseq or seq address phase
  assign take = hsel && hready && htrans[1];
  // reads take one wait state so the data leave a flip-flop
  assign hreadyout = (ahb_st_reg == BCB_AHB_IDLE);
  assign hrdata    = hrdata_reg;
  // every transfer answers okay, unmapped ones included
  assign hresp     = 1'b0;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rd_addr_reg <= '0;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take && hwrite) begin
        wr_addr_reg <= haddr[`BCB_ADDR_W-1:0];
      end
      if (take && !hwrite) begin
        rd_addr_reg <= haddr[`BCB_ADDR_W-1:0];
      end
    end
  end

  // read wait state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_st_reg <= BCB_AHB_IDLE;
    end else begin
      case (ahb_st_reg)
        // a read holds the bus one cycle
        BCB_AHB_IDLE: begin
          if (take && !hwrite) begin
            ahb_st_reg <= BCB_AHB_LOAD;
          end
        end
        default: begin
          ahb_st_reg <= BCB_AHB_IDLE;
        end
      endcase
    end
  end

  // read data load; a write just ahead has already landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (ahb_st_reg == BCB_AHB_LOAD) begin
      hrdata_reg <= rd_mux;
    end
  end

  // read selection, unmapped and reserved bits read zero
  always_comb begin
    rd_mux = '0;
    if (rd_addr_reg == `BCB_CTRL_OFF) begin
      rd_mux[`BCB_CTRL_EN] = en_reg;
      rd_mux[`BCB_CTRL_PROTO_HI:`BCB_CTRL_PROTO_LO] = proto_reg;
      rd_mux[`BCB_CTRL_NSET_HI:`BCB_CTRL_NSET_LO]   = nset_reg;
    end else if (is_set_addr(rd_addr_reg)) begin
      rd_mux = set_reg[set_index(rd_addr_reg)];
    end else if (rd_addr_reg == `BCB_OCC_OFF) begin
      rd_mux[`BCB_NCH*`BCB_CNT_W-1:0] = occ_flat;
    end else if (rd_addr_reg == `BCB_CFGV_OFF) begin
      rd_mux[`BCB_NCH*`BCB_CNT_W-1:0] = depth_flat;
    end else if (rd_addr_reg == `BCB_CFGM_OFF) begin
      rd_mux[4:0]   = byp_flat;
      rd_mux[12:8]  = pipe_flat;
      rd_mux[20:16] = live_flat;
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************

  // control word; flush is a pulse and never reads back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_reg    <= 1'b1;
      proto_reg <= BCB_TL_UL;
      nset_reg  <= BCB_NSET_ZERO;
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= 1'b0;
      if (wr_pend_reg && (wr_addr_reg == `BCB_CTRL_OFF)) begin
        en_reg    <= hwdata[`BCB_CTRL_EN];
        proto_reg <= bcb_proto_t'(
                     hwdata[`BCB_CTRL_PROTO_HI:`BCB_CTRL_PROTO_LO]);
        nset_reg  <= bcb_nset_t'(
                     hwdata[`BCB_CTRL_NSET_HI:`BCB_CTRL_NSET_LO]);
        flush_reg <= hwdata[`BCB_CTRL_FLUSH];
      end
    end
  end

  // setting words; reshaping a busy queue is the user's hazard
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      set_reg <= {`BCB_NCH{`BCB_SET_RST}};
    end else if (wr_pend_reg && is_set_addr(wr_addr_reg)) begin
      set_reg[set_index(wr_addr_reg)] <= hwdata & `BCB_SET_MASK;
    end
  end

  // ****************************************************************
  // channel queues
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `BCB_NCH; g++) begin : g_ch
      bcb_fifo_if #(.WIDTH(`BCB_DATA_W)) q_if ();

      bcb_cfg_t cfg;       // resolved shape
      logic     gate;      // lane live and enabled
      logic     zero;      // no storage configured
      logic     empty;     // queue holds nothing
      logic     room;      // below configured depth
      logic     pop;       // head leaves this cycle
      logic     flow_thru; // beat passes an empty bypass queue

      // shape and liveness of this lane
      assign cfg   = resolve(proto_reg, nset_reg, 3'(g), set_reg);
      assign gate  = en_reg && chan_live(proto_reg, 3'(g));
      assign zero  = (cfg.depth == `BCB_NONE_DEPTH);
      assign empty = (q_if.count == '0);
      assign room  = (q_if.count < cfg.depth);
      assign pop   = !empty && dst_ready[g];
      assign flow_thru = cfg.bypass && empty && dst_ready[g];

      // output valid, direct from input when passing through
      always_comb begin
        if (!gate) begin
          dst_valid[g] = 1'b0;
        end else if (zero) begin
          dst_valid[g] = src_valid[g];
        end else begin
          dst_valid[g] = !empty || (cfg.bypass && src_valid[g]);
        end
      end

      // input ready; low only when the lane is off, the configured depth is used, or a zero-depth lane's far side is not ready
      always_comb begin
        if (!gate) begin
          src_ready[g] = 1'b0;
        end else if (zero) begin
          src_ready[g] = dst_ready[g];
        end else begin
          src_ready[g] = q_if.wr_ready &&
                         (room || (cfg.pipe && pop));
        end
      end

      // payload: stored head, or the arriving beat when passed on
      always_comb begin
        if (zero || (cfg.bypass && empty)) begin
          dst_data[g] = src_data[g];
        end else begin
          dst_data[g] = q_if.rd_data;
        end
      end

      // storage hookup; a bypassed beat is never stored
      assign q_if.clear    = flush_reg;
      assign q_if.wr_valid = src_valid[g] && src_ready[g] &&
                             !zero && !flow_thru;
      assign q_if.wr_data  = src_data[g];
      assign q_if.rd_ready = gate && !zero && dst_ready[g];

      // status views
      assign occ_flat[g*`BCB_CNT_W +: `BCB_CNT_W]   = q_if.count;
      assign depth_flat[g*`BCB_CNT_W +: `BCB_CNT_W] = cfg.depth;
      assign byp_flat[g]  = cfg.bypass;
      assign pipe_flat[g] = cfg.pipe;
      assign live_flat[g] = gate;

      // one storage block per lane
      bcb_fifo #(
        .WIDTH(`BCB_DATA_W),
        .DEPTH(`BCB_FIFO_DEPTH)
      ) u_fifo (
        .hclk    (hclk),
        .hresetn (hresetn),
        .q       (q_if.store)
      );
    end
  endgenerate

  // hsize is not checked: only whole-word transfers are expected
endmodule

// >>> test/bcb_bus_channel_buffer_chk.sv
`timescale 1ns/10ps
`include "bcb_regs.svh"

// ****************************************************************
// port checks on the register bus and the dequeue side
// ****************************************************************
module bcb_bus_channel_buffer_chk (
  // clock and reset
  input wire logic                                 hclk,
  input wire logic                                 hresetn,
  // register port
  input wire logic                                 hsel,
  input wire logic [1:0]                           htrans,
  input wire logic                                 hwrite,
  input wire logic                                 hready,
  input wire logic                                 hreadyout,
  input wire logic [31:0]                          hrdata,
  input wire logic                                 hresp,
  // dequeue side
  input wire logic [`BCB_NCH-1:0]                  dst_valid,
  input wire logic [`BCB_NCH-1:0]                  dst_ready,
  input wire logic [`BCB_NCH-1:0][`BCB_DATA_W-1:0] dst_data
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // accepted address phases
  wire rd_acc = hsel && hready && htrans[1] && !hwrite;
  wire wr_acc = hsel && hready && htrans[1] && hwrite;
  // a read pays exactly one wait state
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait; rd_acc |=> s_one_wait; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait");
  property p_wr_fast; wr_acc |=> hreadyout; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stall");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  // read data only moves while a read is loading
  property p_rdata_hold; hreadyout && !rd_acc |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved");
  // a stalled beat on lane 0 or lane 3 stays offered, unaltered
  property p_v0; dst_valid[0] && !dst_ready[0] |=> dst_valid[0]; endproperty
  a_v0: assert property (p_v0) else $error("lane 0 dropped");
  property p_d0; dst_valid[0] && !dst_ready[0] |=> $stable(dst_data[0]);
  endproperty
  a_d0: assert property (p_d0) else $error("lane 0 data moved");
  property p_v3; dst_valid[3] && !dst_ready[3] |=> dst_valid[3]; endproperty
  a_v3: assert property (p_v3) else $error("lane 3 dropped");
  property p_d3; dst_valid[3] && !dst_ready[3] |=> $stable(dst_data[3]);
  endproperty
  a_d3: assert property (p_d3) else $error("lane 3 data moved");
endmodule

bind bcb_bus_channel_buffer bcb_bus_channel_buffer_chk i_chk (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hrdata, .hresp, .dst_valid, .dst_ready, .dst_data
);

// >>> test/bcb_far_end.sv
`timescale 1ns/10ps
`include "bcb_regs.svh"

// ****************************************************************
// far-side sink: takes every beat unless stalled
// ****************************************************************
module bcb_far_end (
  // reset
  input  wire logic                hresetn,
  // stall request per lane
  input  wire logic [`BCB_NCH-1:0] stall,
  // ready toward the buffer
  output      logic [`BCB_NCH-1:0] dst_ready
);
  // never ready in reset, so no beat is taken then
  assign dst_ready = ~stall & {`BCB_NCH{hresetn}};
endmodule

// >>> test/bcb_bus_channel_buffer_test.sv
`timescale 1ns/10ps
`include "bcb_regs.svh"

// ****************************************************************
// bench: register port plus five stream lanes
// ****************************************************************
module bcb_bus_channel_buffer_test;
  logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]       htrans;
  logic [31:0]      haddr, hwdata, hrdata, q;
  logic [4:0]       src_valid, src_ready, dst_valid, dst_ready, stall;
  logic [4:0][31:0] src_data, dst_data;
  int               n_fail, n_tests;

  bcb_bus_channel_buffer i_bcb_bus_channel_buffer (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .src_valid, .src_ready, .src_data, .dst_valid, .dst_ready, .dst_data
  );
  bcb_far_end i_bcb_far_end (.hresetn, .stall, .dst_ready);

  // 125 MHz
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task end_of_test;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  // sample before the edge: hreadyout is combinational
  task wt;
    logic r;
    for (int i = 0; i < 50; i++) begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      @(posedge hclk);
      if (r === 1'b1) return;
    end
    n_fail++;
    end_of_test;
  endtask

  // one single transfer, entered just after an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    chk(q === e, m);
  endtask

  // push until refused; lane must be stalled
  task fill(input int l, input int n, input logic [31:0] b);
    int k;
    k = 0;
    src_valid[l] <= 1'b1;
    src_data[l] <= b;
    for (int i = 0; i < 40; i++) begin
      @(negedge hclk);
      if (src_ready[l] !== 1'b1) break;
      @(posedge hclk);
      k++;
      src_data[l] <= b + k;
    end
    @(posedge hclk);
    src_valid[l] <= 1'b0;
    chk(k == n, "fill count");
    // never refused: the lane is broken, stop here
    if (k == 40) end_of_test;
  endtask

  // pop with the far side stalling every other cycle
  task drain(input int l, input int n, input logic [31:0] b);
    int j;
    j = 0;
    for (int i = 0; i < 4 * n + 8 && j < n; i++) begin
      stall[l] <= i[0];
      @(negedge hclk);
      if (dst_valid[l] && dst_ready[l]) begin
        chk(dst_data[l] === b + j, "order");
        j++;
      end
      @(posedge hclk);
    end
    stall[l] <= 1'b1;
    chk(j == n, "drain count");
    // bound used up before all beats came out
    if (j != n) end_of_test;
    @(negedge hclk);
    chk(dst_valid[l] === 1'b0, "not empty");
    @(posedge hclk);
  endtask

  task t_reset;
    rd(8'h00, 32'h1, "ctrl reset");
    rd(8'h04, 32'h2000, "set reset");
    bus(1'b0, 8'h1C, 32'h0);
    chk(q[4:0] === 5'h02 && q[19:15] === 5'h02, "default");
    rd(8'h40, 32'h0, "unmapped");
    rd(8'h20, 32'h90000, "ul live");
    fill(0, 2, 32'hA0);
    drain(0, 2, 32'hA0);
  endtask

  task t_one;
    bus(1'b1, 8'h04, 32'h10);
    bus(1'b1, 8'h00, 32'h11);
    bus(1'b0, 8'h1C, 32'h0);
    chk(q[4:0] === 5'h10 && q[19:15] === 5'h10, "one set");
    fill(0, 16, 32'h100);
    rd(8'h18, 32'h10, "occ");
    drain(0, 16, 32'h100);
  endtask

  // zero-depth lane passes straight through
  task t_tlc_two;
    bus(1'b1, 8'h04, 32'h2000);
    bus(1'b1, 8'h08, 32'h3000);
    bus(1'b1, 8'h00, 32'h23);
    rd(8'h1C, 32'h200802, "tl two");
    src_valid[3] <= 1'b1;
    src_data[3] <= 32'h5A;
    @(negedge hclk);
    chk(dst_valid[3] && dst_data[3] === 32'h5A && !src_ready[3], "p");
    @(posedge hclk);
    stall[3] <= 1'b0;
    @(posedge hclk);
    src_valid[3] <= 1'b0;
    stall[3] <= 1'b1;
  endtask

  task t_axi_two;
    bus(1'b1, 8'h04, 32'h4000);
    bus(1'b1, 8'h08, 32'h5000);
    bus(1'b1, 8'h00, 32'h25);
    rd(8'h20, 32'h1F140B, "axi two");
    src_valid[0] <= 1'b1;
    src_data[0] <= 32'hB0;
    @(negedge hclk);
    chk(dst_valid[0] && dst_data[0] === 32'hB0, "bypass");
    @(posedge hclk);
    src_valid[0] <= 1'b0;
    drain(0, 1, 32'hB0);
    fill(2, 1, 32'hC0);
    // let an edge pass so valid is not driven twice in one step
    @(posedge hclk);
    stall[2] <= 1'b0;
    src_valid[2] <= 1'b1;
    src_data[2] <= 32'hC1;
    @(negedge hclk);
    chk(src_ready[2] === 1'b1 && dst_data[2] === 32'hC0, "pipe");
    @(posedge hclk);
    src_valid[2] <= 1'b0;
    drain(2, 1, 32'hC1);
  endtask

  // integer kind drops the bypass bit
  task t_five;
    for (int n = 0; n < 5; n++) begin
      bus(1'b1, 8'(4 + 4 * n), 32'h1100 | 32'(n + 1));
    end
    bus(1'b1, 8'h00, 32'h33);
    rd(8'h1C, 32'h520C41, "tl five");
    rd(8'h20, 32'h1F0000, "int kind");
    fill(4, 5, 32'hE0);
    drain(4, 5, 32'hE0);
    bus(1'b1, 8'h00, 32'h35);
    rd(8'h1C, 32'h520C41, "axi five");
    fill(4, 5, 32'hF0);
    rd(8'h18, 32'h500000, "occ five");
    // flush with lanes disabled: counts clear, lanes go quiet
    bus(1'b1, 8'h00, 32'h134);
    rd(8'h18, 32'h0, "flush");
    chk(src_ready === 5'h0, "off");
  endtask

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {src_valid, src_data} = '0;
    stall = '1;
    hresetn = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_one;
    t_tlc_two;
    t_axi_two;
    t_five;
    end_of_test;
  end
endmodule
